// ### design/dpio_sync.sv
// dpio_sync: two-flop synchroniser for a vector of asynchronous pin levels
// assumes: bits are independent levels; no multi-bit coherence is needed
`timescale 1ns/100ps
module dpio_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // first stage read only by the second stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// ### design/dpio_top.sv
// dpio_top: three-bit port with crystal and stop-release pins plus eight-bit analog-capable port
// assumes: one 10 MHz clock, register master on the same clock, pins resolved by the bench
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module dpio_top
  import dpio_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  // register port
  input  wire logic [dpio_pkg::ADDR_WIDTH-1:0] addr_i,
  input  wire logic [dpio_pkg::DATA_WIDTH-1:0] wr_data_i,
  input  wire logic                          wr_en_i,
  input  wire logic                          rd_en_i,
  output logic      [dpio_pkg::DATA_WIDTH-1:0] rd_data_o,
  // system state
  input  wire logic                          stop_mode_i,
  // three-bit port pins
  input  wire logic [dpio_pkg::P2_WIDTH-1:0] p2_pin_i,
  output logic      [dpio_pkg::P2_WIDTH-1:0] p2_pin_o,
  output logic      [dpio_pkg::P2_WIDTH-1:0] p2_pin_oe_o,
  // eight-bit port pins
  input  wire logic [dpio_pkg::P3_WIDTH-1:0] p3_pin_i,
  output logic      [dpio_pkg::P3_WIDTH-1:0] p3_pin_o,
  output logic      [dpio_pkg::P3_WIDTH-1:0] p3_pin_oe_o,
  // alternate functions
  output logic                               slow_crystal_en_o,
  output logic                               stop_release_pin_o,
  output logic      [dpio_pkg::P3_WIDTH-1:0] analog_channel_en_o,
  output logic      [3:0]                    wakeup_input_o,
  output logic                               ext_interrupt_zero_o,
  output logic                               emergency_stop_input_o,
  // interrupt
  output logic                               irq_o
);
  import dpio_pkg::*;

  logic [P2_WIDTH-1:0] p2_latch_reg;
  logic [P2_WIDTH-1:0] p2_latch_next;
  logic [P3_WIDTH-1:0] p3_data_reg;
  logic [P3_WIDTH-1:0] p3_data_next;
  logic [P3_WIDTH-1:0] p3_dir_reg;
  logic [P3_WIDTH-1:0] p3_dir_next;
  logic [P3_WIDTH-1:0] p3_ictl_reg;
  logic [P3_WIDTH-1:0] p3_ictl_next;
  logic [1:0]          ctrl_reg;
  logic [1:0]          ctrl_next;
  logic [2:0]          irq_stat_reg;
  logic [2:0]          irq_mask_reg;
  logic [2:0]          irq_event;
  logic [P2_WIDTH-1:0] p2_sync;
  logic [P3_WIDTH-1:0] p3_sync;
  logic [P3_WIDTH-1:0] p3_digital;
  logic [P3_WIDTH-1:0] p3_read_val;
  logic                p0_level;
  logic                p0_level_reg;
  logic                ext_int_prev_reg;
  logic                estop_prev_reg;
  logic [7:0]          rd_mux;

  // pin levels cross into the clock domain before any logic sees them
  dpio_sync #(
    .WIDTH (P2_WIDTH + P3_WIDTH)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({p2_pin_i, p3_pin_i}),
    .sync_o    ({p2_sync, p3_sync})
  );

  // write decode; next values other than p3_ictl_next are also used for the pin flops
  always_comb begin
    p2_latch_next = p2_latch_reg;
    p3_data_next  = p3_data_reg;
    p3_dir_next   = p3_dir_reg;
    p3_ictl_next  = p3_ictl_reg;
    ctrl_next     = ctrl_reg;
    if (wr_en_i) begin
      unique case (addr_i)
        ADDR_P2_LATCH: p2_latch_next = wr_data_i[P2_WIDTH-1:0];
        // whole byte lands in the latch, so a read-modify-write copies pin levels into input bits [R15]
        ADDR_P3_DATA:  p3_data_next  = wr_data_i;
        ADDR_P3_DIR:   p3_dir_next   = wr_data_i;       // [R8]
        ADDR_P3_ICTL:  p3_ictl_next  = wr_data_i;       // [R8]
        ADDR_CTRL:     ctrl_next     = wr_data_i[1:0];
        default:       ;
      endcase
    end
  end

  // register storage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p2_latch_reg <= RST_P2_LATCH;  // [R1]
      p3_data_reg  <= RST_P3_DATA;   // [R9]
      p3_dir_reg   <= RST_P3_DIR;    // [R9]
      p3_ictl_reg  <= RST_P3_ICTL;   // [R9]
      ctrl_reg     <= RST_CTRL;
    end else begin
      p2_latch_reg <= p2_latch_next;
      p3_data_reg  <= p3_data_next;
      p3_dir_reg   <= p3_dir_next;
      p3_ictl_reg  <= p3_ictl_next;
      ctrl_reg     <= ctrl_next;
    end
  end

  // three-bit port drivers: sink only, latch one releases the pin [R2]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p2_pin_o    <= 3'h0;
      p2_pin_oe_o <= 3'h0;
    end else begin
      p2_pin_o    <= p2_latch_next;  // [R17]
      p2_pin_oe_o[0] <= ~p2_latch_next[0] & ctrl_next[CTRL_OUT_EN] & ~stop_mode_i;  // [R7]
      // crystal pins are never driven as i/o in dual-clock mode [R3]
      p2_pin_oe_o[2:1] <= ~p2_latch_next[2:1] & {2{ctrl_next[CTRL_OUT_EN] & ~ctrl_next[CTRL_DUAL_CLK]}};
    end
  end

  // eight-bit port drivers change on the same edge as the latch, in the cycle after a write
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p3_pin_o    <= 8'h00;
      p3_pin_oe_o <= 8'h00;
    end else begin
      p3_pin_o    <= p3_data_next;                                      // [R17]
      p3_pin_oe_o <= p3_dir_next & {P3_WIDTH{ctrl_next[CTRL_OUT_EN]}};  // [R8]
    end
  end

  // per-bit digital input path and data read value
  generate
    for (genvar i = 0; i < P3_WIDTH; i++) begin : g_p3_bit
      assign p3_digital[i]  = p3_sync[i] & p3_ictl_reg[i];  // [R12]
      assign p3_read_val[i] = p3_dir_reg[i] ? p3_data_reg[i] : p3_digital[i];  // [R10]
    end
  endgenerate

  // pin zero as the chip sees it: driven value while sinking, else the pin [R4]
  assign p0_level = p2_pin_oe_o[0] ? p2_pin_o[0] : p2_sync[0];

  // alternate-function outputs; a disabled input buffer reads low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      slow_crystal_en_o      <= 1'b0;
      stop_release_pin_o     <= 1'b0;
      analog_channel_en_o    <= 8'h00;
      wakeup_input_o         <= 4'h0;
      ext_interrupt_zero_o   <= 1'b0;
      emergency_stop_input_o <= 1'b0;
    end else begin
      slow_crystal_en_o      <= ctrl_reg[CTRL_DUAL_CLK];                  // [R3]
      stop_release_pin_o     <= p2_sync[0];
      analog_channel_en_o    <= ~p3_dir_reg & ~p3_ictl_reg;               // [R12] [R14]
      wakeup_input_o         <= p3_digital[P3_WAKE_HI:P3_WAKE_LO];        // [R14]
      ext_interrupt_zero_o   <= p3_digital[P3_INT_ZERO_BIT];              // [R14]
      emergency_stop_input_o <= p3_digital[P3_ESTOP_BIT];                 // [R14]
    end
  end

  // falling-edge history resets low, so the zero-reset synchroniser gives no false fall
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p0_level_reg     <= 1'b0;
      ext_int_prev_reg <= 1'b0;
      estop_prev_reg   <= 1'b0;
    end else begin
      p0_level_reg     <= p0_level;
      ext_int_prev_reg <= p3_digital[P3_INT_ZERO_BIT];
      estop_prev_reg   <= p3_digital[P3_ESTOP_BIT];
    end
  end

  assign irq_event[IRQ_STOP_PIN] = p0_level_reg & ~p0_level;  // [R4]
  assign irq_event[IRQ_INT_ZERO] = ext_int_prev_reg & ~p3_digital[P3_INT_ZERO_BIT];
  assign irq_event[IRQ_ESTOP]    = estop_prev_reg & ~p3_digital[P3_ESTOP_BIT];

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= RST_IRQ;
    end else if (wr_en_i && addr_i == ADDR_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~wr_data_i[2:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  // mask register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_mask_reg <= RST_IRQ;
    end else if (wr_en_i && addr_i == ADDR_IRQ_MASK) begin
      irq_mask_reg <= wr_data_i[2:0];
    end
  end

  // interrupt level, one cycle behind the status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read mux; unimplemented upper bits of the three-bit port read zero [R6]
  always_comb begin
    unique case (addr_i)
      ADDR_P2_LATCH: rd_mux = {5'h00, p2_latch_reg};  // [R5]
      ADDR_P2_PIN:   rd_mux = {5'h00, p2_sync};       // [R5]
      ADDR_P3_DATA:  rd_mux = p3_read_val;            // [R10]
      ADDR_P3_DIR:   rd_mux = p3_dir_reg;
      ADDR_P3_ICTL:  rd_mux = p3_ictl_reg;
      ADDR_IRQ_STAT: rd_mux = {5'h00, irq_stat_reg};
      ADDR_IRQ_MASK: rd_mux = {5'h00, irq_mask_reg};
      ADDR_CTRL:     rd_mux = {6'h00, ctrl_reg};
      default:       rd_mux = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      rd_data_o <= rd_mux;
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_p3_write;
    wr_en_i && addr_i == ADDR_P3_DATA;
  endsequence

  sequence s_p0_fall;
    p0_level_reg ##0 !p0_level;
  endsequence

  sequence s_p3_data_read;
    rd_en_i && addr_i == ADDR_P3_DATA;
  endsequence

  a_p2_latch_reset: assert property ($fell(rst_i) |-> p2_latch_reg == 3'h7)  // [R1]
    else $error("three-bit latch not all ones after reset");
  a_p3_reset_vals: assert property ($fell(rst_i) |->  // [R9]
      p3_dir_reg == 8'h00 && p3_ictl_reg == 8'hff && p3_data_reg == 8'h00)
    else $error("eight-bit port reset values wrong");
  a_crystal_pins_free: assert property (ctrl_reg[CTRL_DUAL_CLK] && !wr_en_i |=> p2_pin_oe_o[2:1] == 2'b00)  // [R3]
    else $error("crystal pins driven in dual-clock mode");
  a_p0_fall_latch: assert property (s_p0_fall |=> irq_stat_reg[IRQ_STOP_PIN])  // [R4]
    else $error("pin zero falling edge not latched");
  a_p2_pin_read: assert property (rd_en_i && addr_i == ADDR_P2_PIN |=>  // [R5] [R6]
      rd_data_o == {5'h00, $past(p2_sync)})
    else $error("pin read of three-bit port wrong");
  a_stop_p0_float: assert property (stop_mode_i |=> !p2_pin_oe_o[0])  // [R7]
    else $error("pin zero driven in stop mode");
  a_p3_dir_drive: assert property (wr_en_i && addr_i == ADDR_P3_DIR && ctrl_reg[CTRL_OUT_EN] |=>  // [R8]
      p3_pin_oe_o == $past(wr_data_i))
    else $error("direction write not reflected on enables");
  a_p3_data_read: assert property (s_p3_data_read |=>  // [R10]
      rd_data_o == (($past(p3_dir_reg) & $past(p3_data_reg)) |
                    (~$past(p3_dir_reg) & $past(p3_ictl_reg) & $past(p3_sync))))
    else $error("eight-bit data read wrong");
  a_analog_gate: assert property (p3_ictl_reg == 8'h00 && !wr_en_i |=>  // [R12]
      wakeup_input_o == 4'h0 && !ext_interrupt_zero_o && !emergency_stop_input_o)
    else $error("digital input not gated off");
  a_rmw_latch: assert property (s_p3_write |=> p3_data_reg == $past(wr_data_i))  // [R15]
    else $error("latch did not take whole byte");
  a_p3_write_pins: assert property (s_p3_write ##1 1 |-> p3_pin_o == $past(wr_data_i))  // [R17]
    else $error("latch write not on pins next cycle");
endmodule

// ### pkg/dpio_pkg.sv
// dpio_pkg: register map, reset values and field positions of the dual gpio port block
// assumes: an 8-bit register port on one 10 MHz clock, synchronous active-high reset
// What this block does
// R1 - three-bit port output latch resets to all ones.
// R2 - software writes latch one before using a three-bit pin as input or alternate.
// R3 - dual-clock mode gives pins one and two to the slow crystal, else plain i/o.
// R4 - pin zero falling edge sets interrupt latch even while driven as output.
// R5 - three-bit port latch and pin levels read at separate addresses.
// R6 - unimplemented bits 7 to 3 of three-bit port reads are undefined; this block reads them as zero.
// R7 - in stop mode pin zero floats regardless of global output enable.
// R8 - eight-bit port has per-bit direction (1 output) and input-control registers.
// R9 - reset: direction zeros, input control ones, data latch zero.
// R10 - data read: zero if both clear, pin if input enabled, latch if output.
// R11 - software clears direction then sets input control for digital input use.
// R12 - analog use clears both bits; cleared input control disables digital input.
// R13 - software never sets output direction on an analog pin.
// R14 - every pin feeds analog; bits 6..3 wakeup, bit 1 interrupt, bit 0 emergency.
// R15 - bit-manipulation write stores read-back pin levels into input-mode latches.
// R16 - software avoids port writes and nearby toggling during conversion.
// R17 - latch write shows on output pins in the cycle after the write.
package dpio_pkg;
  localparam int P2_WIDTH = 3;
  localparam int P3_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 8;
  // register offsets
  localparam logic [7:0] ADDR_P2_LATCH = 8'h02;
  localparam logic [7:0] ADDR_P3_DATA = 8'h03;
  localparam logic [7:0] ADDR_P3_DIR = 8'h06;
  localparam logic [7:0] ADDR_P3_ICTL = 8'h07;
  localparam logic [7:0] ADDR_P2_PIN = 8'h0a;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;
  localparam logic [7:0] ADDR_CTRL = 8'h12;
  // reset values
  localparam logic [2:0] RST_P2_LATCH = 3'h7;
  localparam logic [7:0] RST_P3_DATA = 8'h00;
  localparam logic [7:0] RST_P3_DIR = 8'h00;
  localparam logic [7:0] RST_P3_ICTL = 8'hff;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [1:0] RST_CTRL = 2'h2;
  // control register fields
  localparam int CTRL_DUAL_CLK = 0;
  localparam int CTRL_OUT_EN = 1;
  // interrupt status fields
  localparam int IRQ_STOP_PIN = 0;
  localparam int IRQ_INT_ZERO = 1;
  localparam int IRQ_ESTOP = 2;
  // port three alternate function bit positions
  localparam int P3_INT_ZERO_BIT = 1;
  localparam int P3_ESTOP_BIT = 0;
  localparam int P3_WAKE_LO = 3;
  localparam int P3_WAKE_HI = 6;
  localparam int SYNC_STAGES = 2;
endpackage

// ### verification/dpio_pins.sv
// dpio_pins: board model that resolves the pin levels of both ports
// assumes: three-bit port lines carry pull-ups; the board drives every eight-bit pin the port leaves free
`timescale 1ns/100ps
module dpio_pins
  import dpio_pkg::*;
(
  // design drive
  input  wire logic [dpio_pkg::P2_WIDTH-1:0] drv_p2_i,
  input  wire logic [dpio_pkg::P2_WIDTH-1:0] drv_p2_oe_i,
  input  wire logic [dpio_pkg::P3_WIDTH-1:0] drv_p3_i,
  input  wire logic [dpio_pkg::P3_WIDTH-1:0] drv_p3_oe_i,
  // board drive
  input  wire logic [dpio_pkg::P2_WIDTH-1:0] brd_p2_i,
  input  wire logic [dpio_pkg::P3_WIDTH-1:0] brd_p3_i,
  // resolved levels
  output logic      [dpio_pkg::P2_WIDTH-1:0] lvl_p2_o,
  output logic      [dpio_pkg::P3_WIDTH-1:0] lvl_p3_o
);
  // sink-only lines: a driven low beats the pull-up, so pin zero sees its own pulse
  assign lvl_p2_o = brd_p2_i & ~(drv_p2_oe_i & ~drv_p2_i);
  // output bits show the latch, input bits follow the board
  assign lvl_p3_o = (drv_p3_i & drv_p3_oe_i) | (brd_p3_i & ~drv_p3_oe_i);
endmodule

// ### verification/dpio_top_tb.sv
// dpio_top_tb: register-level tests of both ports, pins and interrupt
// assumes: dpio_pins closes the pin loop; reads wait out the two-flop pin latency
`timescale 1ns/100ps
module dpio_top_tb;
  import dpio_pkg::*;
  logic       sys_clk_i, rst_i, wr_en_i, rd_en_i, stop_mode_i, irq_o;
  logic       slow_crystal_en_o, stop_release_pin_o, ext_interrupt_zero_o, emergency_stop_input_o;
  logic [7:0] addr_i, wr_data_i, rd_data_o, p3_pin_i, p3_pin_o, p3_pin_oe_o, analog_channel_en_o, brd_p3, v;
  logic [2:0] p2_pin_i, p2_pin_o, p2_pin_oe_o, brd_p2;
  logic [3:0] wakeup_input_o;
  int         n_errors, checks_done, cyc;

  dpio_top u_dut (.sys_clk_i, .rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .stop_mode_i,
    .p2_pin_i, .p2_pin_o, .p2_pin_oe_o, .p3_pin_i, .p3_pin_o, .p3_pin_oe_o, .slow_crystal_en_o,
    .stop_release_pin_o, .analog_channel_en_o, .wakeup_input_o, .ext_interrupt_zero_o,
    .emergency_stop_input_o, .irq_o);
  dpio_pins u_pins (.drv_p2_i(p2_pin_o), .drv_p2_oe_i(p2_pin_oe_o), .drv_p3_i(p3_pin_o),
    .drv_p3_oe_i(p3_pin_oe_o), .brd_p2_i(brd_p2), .brd_p3_i(brd_p3), .lvl_p2_o(p2_pin_i), .lvl_p3_o(p3_pin_i));

  // 10 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe; ends just after the edge so its effects have landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  initial begin
    rst_i = 1'b1;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    stop_mode_i = 1'b0;
    brd_p2 = 3'h7;
    brd_p3 = 8'h5a;
    cyc = 0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc(ADDR_P2_LATCH, 8'h07, "p2 latch");
    rdc(ADDR_P3_DIR, 8'h00, "p3 dir");
    rdc(ADDR_P3_ICTL, 8'hff, "p3 ictl");
    rdc(ADDR_P3_DATA, 8'h5a, "p3 pin read");
    check("p3 out", p3_pin_o, 8'h00);
    rdc(8'h55, 8'h00, "unmapped");
    $display("test reset values done");
    // mixed directions: bits 1,0 analog, 3,2 digital in, 7..4 out
    wr(ADDR_P3_DATA, 8'hc3);
    wr(ADDR_P3_ICTL, 8'h3c);
    wr(ADDR_P3_DIR, 8'hf0);
    check("p3 oe", p3_pin_oe_o, 8'hf0);
    check("p3 out", p3_pin_o, 8'hc3);
    idle(1);
    check("analog en", analog_channel_en_o, 8'h03);
    idle(4);
    rdc(ADDR_P3_DATA, 8'hc8, "p3 mixed read");
    check("wakeup", {4'h0, wakeup_input_o}, 8'h01);
    // bit set by software read-modify-write
    rd(ADDR_P3_DATA, v);
    wr(ADDR_P3_DATA, v | 8'h10);
    wr(ADDR_P3_ICTL, 8'hff);
    wr(ADDR_P3_DIR, 8'hff);
    rdc(ADDR_P3_DATA, 8'hd8, "p3 latch after set");
    wr(ADDR_P3_DIR, 8'h00);
    $display("test eight-bit port done");
    // falling edges on interrupt zero and emergency stop
    brd_p3 <= 8'h5b;
    idle(5);
    check("ext int and estop", {6'h0, ext_interrupt_zero_o, emergency_stop_input_o}, 8'h03);
    wr(ADDR_IRQ_STAT, 8'h07);
    brd_p3 <= 8'h58;
    idle(6);
    rdc(ADDR_IRQ_STAT, 8'h06, "irq status");
    check("irq masked", {7'h0, irq_o}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h06);
    idle(2);
    check("irq", {7'h0, irq_o}, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h06);
    idle(2);
    check("irq cleared", {7'h0, irq_o}, 8'h00);
    $display("test interrupts done");
    // three-bit port: pin zero driven low, bits 2,1 kept at one
    wr(ADDR_P2_LATCH, 8'h06);
    check("p2 oe", {5'h0, p2_pin_oe_o}, 8'h01);
    check("p2 out", {5'h0, p2_pin_o}, 8'h06);
    idle(5);
    rdc(ADDR_P2_PIN, 8'h06, "p2 pins");
    rdc(ADDR_P2_LATCH, 8'h06, "p2 latch");
    check("stop pin", {7'h0, stop_release_pin_o}, 8'h00);
    rdc(ADDR_IRQ_STAT, 8'h01, "pin zero edge");
    stop_mode_i <= 1'b1;
    idle(2);
    check("p2 oe stop", {5'h0, p2_pin_oe_o}, 8'h00);
    stop_mode_i <= 1'b0;
    wr(ADDR_P2_LATCH, 8'h00);
    idle(1);
    check("p2 oe single", {5'h0, p2_pin_oe_o}, 8'h07);
    wr(ADDR_CTRL, 8'h03);
    idle(1);
    check("p2 oe dual", {5'h0, p2_pin_oe_o}, 8'h01);
    check("crystal", {7'h0, slow_crystal_en_o}, 8'h01);
    // global output enable off releases every pin, whatever the direction
    wr(ADDR_P3_DIR, 8'h0f);
    wr(ADDR_CTRL, 8'h01);
    check("p2 oe global off", {5'h0, p2_pin_oe_o}, 8'h00);
    check("p3 oe global off", p3_pin_oe_o, 8'h00);
    // analog use: direction cleared first, board keeps the lines still
    wr(ADDR_P3_DIR, 8'h00);
    wr(ADDR_P3_ICTL, 8'h00);
    idle(2);
    check("analog all", analog_channel_en_o, 8'hff);
    check("wakeup gated", {4'h0, wakeup_input_o}, 8'h00);
    rdc(ADDR_P3_DATA, 8'h00, "p3 analog read");
    $display("test three-bit port done");
    summarize();
  end
endmodule
